// file: core/pce_regs.svh
`ifndef PCE_REGS_SVH
`define PCE_REGS_SVH
// register word addresses on reg_addr
`define PCE_A_SEL 8'h00
`define PCE_A_PITCH 8'h01
`define PCE_A_MODE 8'h02
`define PCE_A_TGT0 8'h03
`define PCE_A_DUR0 8'h07
`define PCE_A_EXTCNT 8'h0b
`define PCE_A_STS 8'h0c
`define PCE_A_MASK 8'h0d
`define PCE_A_OUTST 8'h0e
`define PCE_NCH 4
// reset values
`define PCE_SEL_RST 2'h0
`define PCE_PITCH_RST 32'h0000_2710
`define PCE_MODE_RST 2'h0
`define PCE_TGT_RST 32'sh0000_0000
`define PCE_DUR_RST 16'h0000
// limits
`define PCE_SEL_MAX 2'h2
`define PCE_PITCH_MAX 32'h4000_0000
`define PCE_TGT_MAX 32'sh4000_0000
`define PCE_TGT_MIN -32'sh4000_0000
// comparison modes
`define PCE_MODE_OFF 2'h0
`define PCE_MODE_FWD 2'h1
`define PCE_MODE_REV 2'h2
`define PCE_MODE_BOTH 2'h3
`define PCE_MODE_FWD_BIT 0
`define PCE_MODE_REV_BIT 1
// timing
`define PCE_CLK_NS 100
`define PCE_MS_NS 1000000
`endif

// file: core/pce_pkg.sv
package pce_pkg;
   typedef enum logic [1:0] {
      PCE_ENC_OFF,
      PCE_ENC_CCW,
      PCE_ENC_CW
   } pce_enc_sel_type;
   typedef struct packed {
      logic signed [31:0] target;
      logic [15:0] dur;
   } pce_chan_type;
   typedef enum logic {
      PCE_T_IDLE,
      PCE_T_HOLD
   } pce_tstate_type;
endpackage

// file: core/pce_top.sv
`timescale 1ns/1ps
`include "pce_regs.svh"
// Overview of operation
// - encoder select: off, count-up CCW, count-up CW
// - 32-bit pitch, 0 to 2^30, resets 10000
// - targets compared with absolute position counter
// - mode 0 off, 1 forward, 2 reverse, 3 both
// - four signed targets, clamped to +-2^30, reset zero
// - reaching target holds output for duration ms
// - four 16-bit durations, reset zero, taken at the next reach
module pce_top import pce_pkg::*; #(
   parameter int MS_CYCLES = `PCE_MS_NS / `PCE_CLK_NS
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic signed [31:0] abs_pos,
   output logic ext_fb_active,
   output logic ext_fb_invert,
   output logic [31:0] ext_pitch,
   output logic signed [31:0] ext_count,
   output logic cmp_out,
   output logic irq
);
   localparam logic [13:0] MS_LAST = 14'(MS_CYCLES - 1);

   // configuration registers
   pce_enc_sel_type sel_r;
   logic [31:0] pitch_r;
   logic [1:0] mode_r;
   pce_chan_type chan_r [`PCE_NCH];
   logic [`PCE_NCH-1:0] sts_r;
   logic [`PCE_NCH-1:0] mask_r;
   logic [31:0] rdata_r;

   // decode
   wire wr_sel = reg_wr && (reg_addr == `PCE_A_SEL);
   wire wr_pitch = reg_wr && (reg_addr == `PCE_A_PITCH);
   wire wr_mode = reg_wr && (reg_addr == `PCE_A_MODE);
   wire wr_sts = reg_wr && (reg_addr == `PCE_A_STS);
   wire wr_mask = reg_wr && (reg_addr == `PCE_A_MASK);
   wire signed [31:0] wd_s = signed'(reg_wdata);

   // out-of-range values are clamped rather than dropped
   wire [1:0] sel_nxt = (reg_wdata[1:0] > `PCE_SEL_MAX) ? `PCE_SEL_MAX
                                                        : reg_wdata[1:0];
   wire [31:0] pitch_nxt = (reg_wdata > `PCE_PITCH_MAX) ? `PCE_PITCH_MAX
                                                        : reg_wdata;
   wire signed [31:0] tgt_nxt = (wd_s > `PCE_TGT_MAX) ? `PCE_TGT_MAX :
                                (wd_s < `PCE_TGT_MIN) ? `PCE_TGT_MIN : wd_s;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sel_r <= PCE_ENC_OFF;
      end else if (clk_en && wr_sel) begin
         sel_r <= pce_enc_sel_type'(sel_nxt);
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pitch_r <= `PCE_PITCH_RST;
      end else if (clk_en && wr_pitch) begin
         pitch_r <= pitch_nxt;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_r <= `PCE_MODE_RST;
      end else if (clk_en && wr_mode) begin
         mode_r <= reg_wdata[1:0];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mask_r <= '0;
      end else if (clk_en && wr_mask) begin
         mask_r <= reg_wdata[`PCE_NCH-1:0];
      end
   end

   assign ext_fb_active = (sel_r != PCE_ENC_OFF);
   assign ext_fb_invert = (sel_r == PCE_ENC_CW);
   assign ext_pitch = pitch_r;

   // external encoder pins: three flops, a change is taken once
   // the second and third agree
   logic [2:0] a_sync_r;
   logic [2:0] b_sync_r;
   logic a_f_r;
   logic b_f_r;
   logic a_p_r;
   logic b_p_r;
   logic signed [31:0] cnt_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         a_sync_r <= '0;
         b_sync_r <= '0;
      end else if (clk_en) begin
         a_sync_r <= {a_sync_r[1:0], enc_a};
         b_sync_r <= {b_sync_r[1:0], enc_b};
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         a_f_r <= 1'b0;
         b_f_r <= 1'b0;
         a_p_r <= 1'b0;
         b_p_r <= 1'b0;
      end else if (clk_en) begin
         if (a_sync_r[1] == a_sync_r[2]) begin
            a_f_r <= a_sync_r[2];
         end
         if (b_sync_r[1] == b_sync_r[2]) begin
            b_f_r <= b_sync_r[2];
         end
         a_p_r <= a_f_r;
         b_p_r <= b_f_r;
      end
   end

   // one quadrature edge per step; a double change is a lost step and
   // is ignored rather than guessed
   wire a_chg = a_f_r ^ a_p_r;
   wire b_chg = b_f_r ^ b_p_r;
   wire enc_step = a_chg ^ b_chg;
   wire enc_up_raw = a_p_r ^ b_f_r;
   wire enc_up = enc_up_raw ^ ext_fb_invert;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_r <= '0;
      end else if (clk_en && enc_step && ext_fb_active) begin
         cnt_r <= enc_up ? cnt_r + 32'sh1 : cnt_r - 32'sh1;
      end
   end

   assign ext_count = cnt_r;

   // previous position sample; armed after the first sample so a
   // reset-time jump does not look like a crossing
   logic signed [31:0] prev_r;
   logic armed_r;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         prev_r <= '0;
         armed_r <= 1'b0;
      end else if (clk_en) begin
         prev_r <= abs_pos;
         armed_r <= 1'b1;
      end
   end

   logic [`PCE_NCH-1:0] fire;
   logic [`PCE_NCH-1:0] active;
   wire fwd_en = mode_r[`PCE_MODE_FWD_BIT];
   wire rev_en = mode_r[`PCE_MODE_REV_BIT];

   genvar g;
   generate
      for (g = 0; g < `PCE_NCH; g++) begin : g_ch
         wire [7:0] a_tgt = 8'(`PCE_A_TGT0 + g);
         wire [7:0] a_dur = 8'(`PCE_A_DUR0 + g);
         wire wr_tgt = reg_wr && (reg_addr == a_tgt);
         wire wr_dur = reg_wr && (reg_addr == a_dur);
         wire signed [31:0] tgt = chan_r[g].target;
         wire up_x = (prev_r < tgt) && (abs_pos >= tgt);
         wire dn_x = (prev_r > tgt) && (abs_pos <= tgt);
         pce_tstate_type st_r;
         logic [13:0] cyc_r;
         logic [15:0] ms_r;

         // one process per channel word keeps a single driver per element
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               chan_r[g].target <= `PCE_TGT_RST;
               chan_r[g].dur <= `PCE_DUR_RST;
            end else if (clk_en) begin
               if (wr_tgt) begin
                  chan_r[g].target <= tgt_nxt;
               end
               if (wr_dur) begin
                  chan_r[g].dur <= reg_wdata[15:0];
               end
            end
         end

         // crossing outside the selected direction is ignored
         assign fire[g] = armed_r && ((fwd_en && up_x) || (rev_en && dn_x));

         // a crossing with a nonzero duration restarts the hold with the present duration
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               st_r <= PCE_T_IDLE;
               cyc_r <= '0;
               ms_r <= '0;
            end else if (clk_en) begin
               if (fire[g] && (chan_r[g].dur != '0)) begin
                  st_r <= PCE_T_HOLD;
                  ms_r <= chan_r[g].dur;
                  cyc_r <= MS_LAST;
               end else begin
                  case (st_r)
                     PCE_T_IDLE: begin
                        cyc_r <= '0;
                     end
                     PCE_T_HOLD: begin
                        if (cyc_r != '0) begin
                           cyc_r <= cyc_r - 14'h1;
                        end else if (ms_r == 16'h1) begin
                           ms_r <= '0;
                           st_r <= PCE_T_IDLE;
                        end else begin
                           ms_r <= ms_r - 16'h1;
                           cyc_r <= MS_LAST;
                        end
                     end
                     default: begin
                        st_r <= PCE_T_IDLE;
                     end
                  endcase
               end
            end
         end

         assign active[g] = (st_r == PCE_T_HOLD);

         // hold length in cycles, for the check below
         logic [31:0] hold_cnt_r;
         always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
               hold_cnt_r <= '0;
            end else if (clk_en) begin
               if (fire[g]) begin
                  hold_cnt_r <= '0;
               end else if (active[g]) begin
                  hold_cnt_r <= hold_cnt_r + 32'h1;
               end
            end
         end

         property p_hold_len;
            @(posedge sys_clk) disable iff (rst)
            active[g] |-> hold_cnt_r < 32'(chan_r[g].dur) * 32'(MS_CYCLES) + 32'h1;
         endproperty
         a_hold_len: assert property (p_hold_len)
            else $error("hold exceeds programmed duration");

         property p_tgt_clamp;
            @(posedge sys_clk) disable iff (rst)
            tgt <= `PCE_TGT_MAX && tgt >= `PCE_TGT_MIN;
         endproperty
         a_tgt_clamp: assert property (p_tgt_clamp)
            else $error("target out of range");
      end
   endgenerate

   // sticky reach events; a new event beats a clear in the same cycle
   wire [`PCE_NCH-1:0] sts_clr = wr_sts ? reg_wdata[`PCE_NCH-1:0] : '0;
   wire [`PCE_NCH-1:0] sts_nxt = (sts_r & ~sts_clr) | fire;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sts_r <= '0;
      end else if (clk_en) begin
         sts_r <= sts_nxt;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
         cmp_out <= 1'b0;
      end else if (clk_en) begin
         irq <= |(sts_nxt & mask_r);
         cmp_out <= |active;
      end
   end

   // read mux
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      if (reg_addr == `PCE_A_SEL) begin
         rd_mux = {30'h0, sel_r};
      end else if (reg_addr == `PCE_A_PITCH) begin
         rd_mux = pitch_r;
      end else if (reg_addr == `PCE_A_MODE) begin
         rd_mux = {30'h0, mode_r};
      end else if (reg_addr >= `PCE_A_TGT0 && reg_addr < `PCE_A_DUR0) begin
         rd_mux = chan_r[2'(reg_addr - `PCE_A_TGT0)].target;
      end else if (reg_addr >= `PCE_A_DUR0 && reg_addr < `PCE_A_EXTCNT) begin
         rd_mux = {16'h0, chan_r[2'(reg_addr - `PCE_A_DUR0)].dur};
      end else if (reg_addr == `PCE_A_EXTCNT) begin
         rd_mux = cnt_r;
      end else if (reg_addr == `PCE_A_STS) begin
         rd_mux = {28'h0, sts_r};
      end else if (reg_addr == `PCE_A_MASK) begin
         rd_mux = {28'h0, mask_r};
      end else if (reg_addr == `PCE_A_OUTST) begin
         rd_mux = {27'h0, cmp_out, active};
      end
   end

   // read data stands one cycle only
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rdata_r <= '0;
      end else if (clk_en) begin
         rdata_r <= reg_rd ? rd_mux : '0;
      end
   end

   assign reg_rdata = rdata_r;

   property p_sel_range;
      @(posedge sys_clk) disable iff (rst)
      sel_r <= PCE_ENC_CW;
   endproperty
   a_sel_range: assert property (p_sel_range)
      else $error("encoder select out of range");

   property p_enc_up;
      @(posedge sys_clk) disable iff (rst)
      clk_en && enc_step && sel_r == PCE_ENC_CCW && enc_up_raw |=>
         cnt_r == $past(cnt_r) + 32'sh1;
   endproperty
   a_enc_up: assert property (p_enc_up)
      else $error("encoder count did not step up");

   property p_enc_off;
      @(posedge sys_clk) disable iff (rst)
      sel_r == PCE_ENC_OFF |=> $stable(cnt_r);
   endproperty
   a_enc_off: assert property (p_enc_off)
      else $error("encoder counted while unused");

   property p_pitch_max;
      @(posedge sys_clk) disable iff (rst)
      clk_en && wr_pitch |=> pitch_r <= `PCE_PITCH_MAX && pitch_r == $past(pitch_nxt);
   endproperty
   a_pitch_max: assert property (p_pitch_max)
      else $error("pitch write wrong");

   property p_mode_off;
      @(posedge sys_clk) disable iff (rst)
      mode_r == `PCE_MODE_OFF |-> fire == '0;
   endproperty
   a_mode_off: assert property (p_mode_off)
      else $error("compare fired while disabled");

   property p_fwd_only;
      @(posedge sys_clk) disable iff (rst)
      mode_r == `PCE_MODE_FWD && fire[0] |-> abs_pos > prev_r;
   endproperty
   a_fwd_only: assert property (p_fwd_only)
      else $error("forward mode fired on falling position");

   property p_rev_only;
      @(posedge sys_clk) disable iff (rst)
      mode_r == `PCE_MODE_REV && fire[0] |-> abs_pos < prev_r;
   endproperty
   a_rev_only: assert property (p_rev_only)
      else $error("reverse mode fired on rising position");

   property p_out_on;
      @(posedge sys_clk) disable iff (rst)
      clk_en && fire[0] && chan_r[0].dur != '0 ##1 clk_en |=> cmp_out;
   endproperty
   a_out_on: assert property (p_out_on)
      else $error("output not raised after reach");

   property p_sticky;
      @(posedge sys_clk) disable iff (rst)
      clk_en && fire[1] |=> sts_r[1];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("reach event lost");

endmodule // pce_top

// file: verification/pce_enc_model.sv
`timescale 1ns/1ps
// external incremental encoder: one quadrature step per strobe
module pce_enc_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic step_up,
   input wire logic step_dn,
   output logic enc_a,
   output logic enc_b
);
   logic [1:0] ph_r;
   // gray order 00,01,11,10 so only one pin moves per step
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ph_r <= 2'h0;
      end else if (step_up) begin
         ph_r <= ph_r + 2'h1;
      end else if (step_dn) begin
         ph_r <= ph_r - 2'h1;
      end
   end
   assign enc_a = ph_r[1];
   assign enc_b = ph_r[1] ^ ph_r[0];
endmodule // pce_enc_model

// file: verification/pce_top_test.sv
`timescale 1ns/1ps
`include "pce_regs.svh"
module pce_top_test import pce_pkg::*;;
   localparam int MS = 4;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic clk_en = 1'b1;
   logic step_up = 1'b0;
   logic step_dn = 1'b0;
   logic signed [31:0] abs_pos = 32'sh0;
   logic [31:0] reg_rdata, ext_pitch;
   logic signed [31:0] ext_count;
   logic enc_a, enc_b, ext_fb_active, ext_fb_invert, cmp_out, irq;
   int error_cnt = 0;
   int checks_done = 0;
   int cyc = 0;
   int n;
   always #50 sys_clk = ~sys_clk;
   pce_top #(.MS_CYCLES(MS)) dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .enc_a(enc_a), .enc_b(enc_b), .abs_pos(abs_pos),
      .ext_fb_active(ext_fb_active), .ext_fb_invert(ext_fb_invert),
      .ext_pitch(ext_pitch), .ext_count(ext_count), .cmp_out(cmp_out), .irq(irq));
   pce_enc_model enc (.sys_clk(sys_clk), .rst(rst), .step_up(step_up), .step_dn(step_dn),
      .enc_a(enc_a), .enc_b(enc_b));
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checks_done++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe, so look right there
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask
   // each pin state is held at least 10 cycles, well past the input filter
   task automatic step(input logic up);
      @(posedge sys_clk);
      step_up <= up;
      step_dn <= !up;
      @(posedge sys_clk);
      step_up <= 1'b0;
      step_dn <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic move(input logic signed [31:0] p);
      @(posedge sys_clk);
      abs_pos <= p;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   // counts cycles with the output high over a fixed window
   task automatic hold_cnt();
      n = 0;
      repeat (40) begin
         @(posedge sys_clk);
         #1;
         if (cmp_out === 1'b1) n++;
      end
   endtask
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rd(`PCE_A_SEL, 32'h0);
      rd(`PCE_A_PITCH, 32'h0000_2710);
      chk("ext_pitch", 32'h0000_2710, ext_pitch);
      rd(`PCE_A_MODE, 32'h0);
      for (int i = 0; i < 4; i++) begin
         rd(8'(`PCE_A_TGT0 + i), 32'h0);
         rd(8'(`PCE_A_DUR0 + i), 32'h0);
      end
      rd(8'hff, 32'h0);
      wr(`PCE_A_SEL, 32'h3);
      rd(`PCE_A_SEL, 32'h2);
      chk("ext_fb_invert", 32'h1, {31'h0, ext_fb_invert});
      wr(`PCE_A_SEL, 32'h1);
      rd(`PCE_A_SEL, 32'h1);
      chk("ext_fb_active", 32'h1, {31'h0, ext_fb_active});
      chk("ext_fb_invert", 32'h0, {31'h0, ext_fb_invert});
      wr(`PCE_A_PITCH, 32'h4000_0001);
      rd(`PCE_A_PITCH, 32'h4000_0000);
      wr(`PCE_A_PITCH, 32'h0000_1234);
      rd(`PCE_A_PITCH, 32'h0000_1234);
      chk("ext_pitch", 32'h0000_1234, ext_pitch);
      // far targets on 2 and 3 keep them out of the crossings below
      wr(8'(`PCE_A_TGT0 + 2), 32'h7fff_ffff);
      rd(8'(`PCE_A_TGT0 + 2), 32'h4000_0000);
      wr(8'(`PCE_A_TGT0 + 3), 32'hbfff_ffff);
      rd(8'(`PCE_A_TGT0 + 3), 32'hc000_0000);
      wr(8'(`PCE_A_TGT0 + 1), 32'h0000_012c);
      wr(`PCE_A_TGT0, 32'h0000_0064);
      for (int i = 0; i < 4; i++) step(1'b1);
      chk("ext_count", 32'h4, ext_count);
      // with the enable low the pin filter must not take the step
      clk_en <= 1'b0;
      step(1'b1);
      chk("ext_count frozen", 32'h4, ext_count);
      clk_en <= 1'b1;
      repeat (8) @(posedge sys_clk);
      chk("ext_count", 32'h5, ext_count);
      wr(`PCE_A_SEL, {30'h0, PCE_ENC_CW});
      step(1'b1);
      step(1'b1);
      step(1'b0);
      chk("ext_count", 32'h4, ext_count);
      wr(`PCE_A_SEL, 32'h0);
      step(1'b1);
      rd(`PCE_A_EXTCNT, 32'h4);
      chk("ext_fb_active", 32'h0, {31'h0, ext_fb_active});
      wr(`PCE_A_MASK, 32'hf);
      wr(`PCE_A_DUR0, 32'h1);
      for (int m = 0; m < 4; m++) begin
         wr(`PCE_A_MODE, 32'(m));
         wr(`PCE_A_STS, 32'hf);
         move(32'sh0000_00c8);
         chk("cmp_out fwd", 32'(m & 1), {31'h0, cmp_out});
         chk("irq fwd", 32'(m & 1), {31'h0, irq});
         rd(`PCE_A_STS, 32'(m & 1));
         wr(`PCE_A_STS, 32'h1);
         repeat (8) @(posedge sys_clk);
         #1;
         chk("irq clear", 32'h0, {31'h0, irq});
         chk("cmp_out end", 32'h0, {31'h0, cmp_out});
         move(32'sh0000_0000);
         chk("cmp_out rev", 32'(m >> 1), {31'h0, cmp_out});
         rd(`PCE_A_STS, 32'(m >> 1));
         wr(`PCE_A_STS, 32'hf);
         repeat (8) @(posedge sys_clk);
      end
      wr(`PCE_A_MODE, 32'h1);
      wr(`PCE_A_DUR0, 32'h2);
      @(posedge sys_clk);
      abs_pos <= 32'sh0000_00c8;
      hold_cnt();
      // two milliseconds of four-cycle ticks, exactly
      chk("hold cycles", 32'(2 * MS), 32'(n));
      wr(`PCE_A_STS, 32'hf);
      @(posedge sys_clk);
      abs_pos <= 32'sh0000_0190;
      hold_cnt();
      chk("hold zero", 32'h0, 32'(n));
      rd(`PCE_A_STS, 32'h2);
      tally_and_finish();
   end
endmodule // pce_top_test
